/* hdl/pcf_cfg.svh */
// constants of the clock fan-out model: counts, widths and bank sizes
// assumes inclusion by bare name from the package and from design files
`ifndef PCF_CFG_SVH
`define PCF_CFG_SVH

// system clock rate and the longest lock settling time
`define PCF_MCLK_MHZ      125
`define PCF_LOCK_TIME_US  1000

// counter widths
`define PCF_PERIOD_W      16
`define PCF_LOCK_W        17

// reference period bounds, in mclk cycles
`define PCF_PERIOD_ONE    16'h0001
`define PCF_PERIOD_MIN    16'h0002
`define PCF_PERIOD_MAX    16'hFFFF

// bank sizes
`define PCF_BANK_A_N      5
`define PCF_BANK_B_N      4

`endif

/* hdl/pcf_pkg.sv */
// types shared by the clock fan-out model
// assumes pcf_cfg.svh is reachable on the include path
`include "pcf_cfg.svh"

package pcf_pkg;

  // reference period measurement
  typedef struct packed {
    logic [`PCF_PERIOD_W-1:0] period;
    logic                     valid;
    logic                     changed;
  } pcf_meas_t;

  // every clock copy the block drives
  typedef struct packed {
    logic [`PCF_BANK_A_N-1:0] bankA;
    logic [`PCF_BANK_B_N-1:0] bankB;
    logic                     loopReturn;
  } pcf_fanout_t;

  typedef enum logic [1:0] {
    PCF_SEARCH,
    PCF_SETTLE,
    PCF_LOCKED
  } pcf_lock_state_t;

endpackage

/* hdl/pcf_duty_regen.sv */
// reference period measurement and 50 percent duty regeneration
// assumes refRise is a one-cycle pulse on each sampled reference rise
`timescale 1ns/1ps
`include "pcf_cfg.svh"

module pcf_duty_regen (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // reference edge
  input  wire logic          refRise,
  // regenerated clock and measurement
  output logic               regenClk,
  output pcf_pkg::pcf_meas_t meas
);

  logic [`PCF_PERIOD_W-1:0] cntReg;
  logic [`PCF_PERIOD_W-1:0] highCntReg;
  logic [`PCF_PERIOD_W-1:0] half;
  logic                     regenReg;
  pcf_pkg::pcf_meas_t       measReg;

  function automatic logic [`PCF_PERIOD_W-1:0] satInc(
    input logic [`PCF_PERIOD_W-1:0] v
  );
    return (v == `PCF_PERIOD_MAX) ? v : v + `PCF_PERIOD_ONE;
  endfunction

  // a saturated count means the reference stopped
  function automatic logic periodOk(input logic [`PCF_PERIOD_W-1:0] v);
    return (v >= `PCF_PERIOD_MIN) && (v != `PCF_PERIOD_MAX);
  endfunction

  assign half     = measReg.period >> 1;
  assign regenClk = regenReg;
  assign meas     = measReg;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cntReg <= `PCF_PERIOD_MAX; // saturated: first rise only opens a count
    else if (refRise)
      cntReg <= `PCF_PERIOD_ONE;
    else
      cntReg <= satInc(cntReg);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      measReg <= '0;
    else if (refRise)
    begin
      measReg.period  <= cntReg;
      measReg.valid   <= periodOk(cntReg);
      measReg.changed <= measReg.valid && (cntReg != measReg.period);
    end
    else
    begin
      measReg.changed <= 1'b0;
      if (cntReg == `PCF_PERIOD_MAX)
        measReg.valid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      highCntReg <= '0;
    else if (refRise)
      highCntReg <= `PCF_PERIOD_ONE;
    else
      highCntReg <= satInc(highCntReg);
  end

  // high for half the measured period, low for the rest
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      regenReg <= 1'b0;
    else if (refRise)
      regenReg <= periodOk(cntReg);
    else if (highCntReg >= half)
      regenReg <= 1'b0;
  end

  a_duty_half_high:
    assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(regenReg) |-> $past(highCntReg) == $past(half))
    else $error("regenerated high phase differs from half period");

endmodule

/* hdl/pcf_clock_fanout.sv */
// clock fan-out model: two gated banks and a loop return copy
// assumes all inputs are synchronous to mclk and the reference period
// spans several mclk cycles; loop return out is wired to loop return in
`timescale 1ns/1ps
`include "pcf_cfg.svh"

// Function
// - first bank enable low holds all five first-bank outputs low.
// - first bank enable high makes five first-bank outputs copy the reference.
// - second bank enable low holds all four second-bank outputs low.
// - second bank enable high makes four second-bank outputs copy reference.
// - enabled outputs toggle in phase and frequency with the reference.
// - loop return output always toggles, whatever the bank enables.
// - outside bypass every output is regenerated at 50 percent duty; bypass keeps the reference duty.
// - analog supply tied low bypasses the loop, buffering reference straight.
// - after start or disturbance, lock needs a settling period first.
// - reference frequency lies between 50 and 150 MHz.
// - settling to lock takes at most one millisecond.
module pcf_clock_fanout #(
  parameter int unsigned LOCK_CYCLES = `PCF_LOCK_TIME_US * `PCF_MCLK_MHZ
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // reference and loop
  input  wire logic                     refClkIn,
  input  wire logic                     loopReturnIn,
  input  wire logic                     analogSupply,
  // bank gates
  input  wire logic                     bankAEnable,
  input  wire logic                     bankBEnable,
  // clock copies
  output logic [`PCF_BANK_A_N-1:0]      bankAClockOutputs,
  output logic [`PCF_BANK_B_N-1:0]      bankBClockOutputs,
  output logic                          loopReturnOut,
  // status
  output logic                          phaseLocked
);

  logic                     refReg;
  logic                     refPrevReg;
  logic                     refRise;
  logic                     bypass;
  logic                     regenClk;
  logic                     clkNext;
  logic                     gateAReg;
  logic                     gateBReg;
  logic                     gateANext;
  logic                     gateBNext;
  logic                     loopMismatch;
  logic                     disturb;
  logic                     lockDone;
  logic [`PCF_LOCK_W-1:0]   lockCntReg;
  logic                     phaseLockedReg;
  pcf_pkg::pcf_meas_t       meas;
  pcf_pkg::pcf_fanout_t     fanoutReg;
  pcf_pkg::pcf_fanout_t     fanoutNext;
  pcf_pkg::pcf_lock_state_t lockStateReg;

  // reference sampling and edge detect
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refReg     <= 1'b0;
      refPrevReg <= 1'b0;
    end
    else
    begin
      refReg     <= refClkIn;
      refPrevReg <= refReg;
    end
  end

  assign refRise = refReg & ~refPrevReg;

  pcf_duty_regen i_pcf_duty_regen (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .refRise  (refRise),
    .regenClk (regenClk),
    .meas     (meas)
  );

  // the bypass tap is one stage late so both paths share one latency
  assign bypass  = ~analogSupply;
  assign clkNext = bypass ? refPrevReg : regenClk;

  // a gate only follows its enable while the clock is low; an enable
  // edge during a high phase waits for that phase to end
  assign gateANext = clkNext ? gateAReg : bankAEnable;
  assign gateBNext = clkNext ? gateBReg : bankBEnable;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gateAReg <= 1'b0;
      gateBReg <= 1'b0;
    end
    else
    begin
      gateAReg <= gateANext;
      gateBReg <= gateBNext;
    end
  end

  always_comb
  begin
    fanoutNext.bankA      = {`PCF_BANK_A_N{gateANext & clkNext}};
    fanoutNext.bankB      = {`PCF_BANK_B_N{gateBNext & clkNext}};
    fanoutNext.loopReturn = clkNext;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      fanoutReg <= '0;
    else
      fanoutReg <= fanoutNext;
  end

  assign bankAClockOutputs = fanoutReg.bankA;
  assign bankBClockOutputs = fanoutReg.bankB;
  assign loopReturnOut     = fanoutReg.loopReturn;

  // the board wire makes loopReturnIn equal to loopReturnOut in the
  // same cycle; any difference means the loop is open or disturbed
  assign loopMismatch = loopReturnIn != fanoutReg.loopReturn;

  // a new reference period or a broken loop restarts the settle count
  assign disturb  = meas.changed || loopMismatch;
  assign lockDone = lockCntReg == `PCF_LOCK_W'(LOCK_CYCLES - 1);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      lockStateReg <= pcf_pkg::PCF_SEARCH;
    else if (bypass || !meas.valid)
      lockStateReg <= pcf_pkg::PCF_SEARCH;
    else
    begin
      case (lockStateReg)
        pcf_pkg::PCF_SEARCH:
          lockStateReg <= pcf_pkg::PCF_SETTLE;
        pcf_pkg::PCF_SETTLE:
          if (!disturb && lockDone)
            lockStateReg <= pcf_pkg::PCF_LOCKED;
        pcf_pkg::PCF_LOCKED:
          if (disturb)
            lockStateReg <= pcf_pkg::PCF_SETTLE;
        default:
          lockStateReg <= pcf_pkg::PCF_SEARCH;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      lockCntReg <= '0;
    else if (lockStateReg != pcf_pkg::PCF_SETTLE || disturb)
      lockCntReg <= '0;
    else if (!lockDone)
      lockCntReg <= lockCntReg + `PCF_LOCK_W'(1);
  end

  // in bypass the loop is off, so lock is never claimed
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      phaseLockedReg <= 1'b0;
    else if (bypass || !meas.valid || disturb)
      phaseLockedReg <= 1'b0;
    else if (lockStateReg == pcf_pkg::PCF_SETTLE && lockDone)
      phaseLockedReg <= 1'b1;
  end

  assign phaseLocked = phaseLockedReg;

  a_bank_a_low:
    assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(fanoutReg.bankA[0]) |-> $past(bankAEnable, 2))
    else $error("first bank rose while its enable was low");

  a_bank_a_copy:
    assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(fanoutReg.loopReturn) && $past(bankAEnable, 2)
        |-> fanoutReg.bankA == '1)
    else $error("enabled first bank missed a clock rise");

  a_bank_b_low:
    assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(fanoutReg.bankB[0]) |-> $past(bankBEnable, 2))
    else $error("second bank rose while its enable was low");

  a_bank_b_copy:
    assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(fanoutReg.loopReturn) && $past(bankBEnable, 2)
        |-> fanoutReg.bankB == '1)
    else $error("enabled second bank missed a clock rise");

  a_phase_follow:
    assert property (@(posedge mclk) disable iff (!rst_n)
      refRise && (bypass || meas.valid) ##1 bypass == $past(bypass)
        |-> ##1 fanoutReg.loopReturn)
    else $error("clock copy did not follow reference rise");

  a_loop_free:
    assert property (@(posedge mclk) disable iff (!rst_n)
      refRise && meas.valid && !bypass && !bankAEnable && !bankBEnable
        |-> ##2 fanoutReg.loopReturn)
    else $error("loop return stopped with banks disabled");

  a_bypass_path:
    assert property (@(posedge mclk) disable iff (!rst_n)
      bypass && $past(bypass)
        |-> fanoutReg.loopReturn == $past(refReg, 2))
    else $error("bypass output differs from sampled reference");

  a_disturb_unlock:
    assert property (@(posedge mclk) disable iff (!rst_n)
      disturb |=> !phaseLockedReg && lockCntReg == '0)
    else $error("disturbance did not drop lock");

  a_lock_bound:
    assert property (@(posedge mclk) disable iff (!rst_n)
      lockStateReg == pcf_pkg::PCF_SETTLE && lockDone && !disturb
        && meas.valid && !bypass |=> phaseLockedReg)
    else $error("lock not declared at end of settle time");

  a_gate_low_only:
    assert property (@(posedge mclk) disable iff (!rst_n)
      ($changed(gateAReg) || $changed(gateBReg))
        |-> !fanoutReg.loopReturn)
    else $error("bank gate changed during a high phase");

  a_gate_follow:
    assert property (@(posedge mclk) disable iff (!rst_n)
      !clkNext |=> gateAReg == $past(bankAEnable)
        && gateBReg == $past(bankBEnable))
    else $error("bank gate missed its enable in a low phase");

  a_bank_a_parked:
    assert property (@(posedge mclk) disable iff (!rst_n)
      !gateAReg |-> fanoutReg.bankA == '0)
    else $error("first bank high with its gate shut");

  a_bank_b_parked:
    assert property (@(posedge mclk) disable iff (!rst_n)
      !gateBReg |-> fanoutReg.bankB == '0)
    else $error("second bank high with its gate shut");

  a_bank_pairs:
    assert property (@(posedge mclk) disable iff (!rst_n)
      (fanoutReg.bankA == '0 || fanoutReg.bankA == '1)
        && (fanoutReg.bankB == '0 || fanoutReg.bankB == '1))
    else $error("copies within one bank disagree");

  a_search_to_settle:
    assert property (@(posedge mclk) disable iff (!rst_n)
      lockStateReg == pcf_pkg::PCF_SEARCH && meas.valid && !bypass
        |=> lockStateReg == pcf_pkg::PCF_SETTLE)
    else $error("valid reference did not start the settle time");

  a_settle_restart:
    assert property (@(posedge mclk) disable iff (!rst_n)
      lockStateReg == pcf_pkg::PCF_LOCKED && disturb && meas.valid
        && !bypass |=> lockStateReg == pcf_pkg::PCF_SETTLE)
    else $error("disturbance did not restart the settle time");

  a_lost_ref_unlock:
    assert property (@(posedge mclk) disable iff (!rst_n)
      !meas.valid |=> !phaseLockedReg)
    else $error("lock held without a valid reference");

  a_bypass_unlocked:
    assert property (@(posedge mclk) disable iff (!rst_n)
      bypass |=> !phaseLockedReg && lockStateReg == pcf_pkg::PCF_SEARCH)
    else $error("lock claimed while the loop is bypassed");

  a_locked_state:
    assert property (@(posedge mclk) disable iff (!rst_n)
      phaseLockedReg == (lockStateReg == pcf_pkg::PCF_LOCKED))
    else $error("lock flag disagrees with lock state");

  a_lock_after_settle:
    assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(phaseLockedReg) |-> $past(lockStateReg) == pcf_pkg::PCF_SETTLE
        && $past(lockDone))
    else $error("lock declared before the settle time ran out");

  a_lock_count_cap:
    assert property (@(posedge mclk) disable iff (!rst_n)
      lockCntReg <= `PCF_LOCK_W'(LOCK_CYCLES - 1))
    else $error("settle count ran past the lock time");

endmodule

/* testbench/pcf_ref_partner.sv */
// reference source and board wire facing the clock fan-out block
// assumes mclk rising edge timing; it drives on the falling edge
`timescale 1ns/1ps

module pcf_ref_partner (
  // timing
  input  wire logic       mclk,
  input  wire logic [7:0] period,
  input  wire logic [7:0] highTime,
  // board
  input  wire logic       loopReturnOut,
  input  wire logic       openLoop,
  output logic            refClkIn,
  output logic            loopReturnIn
);
  logic [7:0] phaseReg = 8'h00;

  // fixed frequency and phase while period stays put
  always @(negedge mclk)
  begin
    phaseReg <= (phaseReg + 8'h01 >= period) ? 8'h00 : phaseReg + 8'h01;
    refClkIn <= (phaseReg < highTime);
  end

  // zero delay wire, as the loop mismatch check expects; openLoop
  // models a broken board trace so the unlock path gets exercised
  assign loopReturnIn = loopReturnOut & ~openLoop;
endmodule

/* testbench/tb_pcf_clock_fanout.sv */
// self-checking bench for the clock fan-out block
// assumes the reference partner drives refClkIn and closes the loop
`timescale 1ns/1ps
`include "pcf_cfg.svh"

module tb_pcf_clock_fanout;
  localparam int LockCycles = 20;
  logic                     mclk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     analogSupply = 1'b1;
  logic                     bankAEnable = 1'b1;
  logic                     bankBEnable = 1'b1;
  logic [7:0]               period = 8'h08;
  logic [7:0]               highTime = 8'h02;
  logic                     openLoop = 1'b0;
  logic                     refClkIn;
  logic                     loopReturnIn;
  logic                     loopReturnOut;
  logic                     phaseLocked;
  logic [`PCF_BANK_A_N-1:0] bankAClockOutputs;
  logic [`PCF_BANK_B_N-1:0] bankBClockOutputs;
  int failures = 0;
  int numChecks = 0;
  int cycles = 0;
  int hiLoop, riseLoop, badA, badB, runts, pulsesA, runA;

  pcf_clock_fanout #(.LOCK_CYCLES(LockCycles)) i_pcf_clock_fanout (
    .mclk(mclk), .rst_n(rst_n), .refClkIn(refClkIn),
    .loopReturnIn(loopReturnIn), .analogSupply(analogSupply),
    .bankAEnable(bankAEnable), .bankBEnable(bankBEnable),
    .bankAClockOutputs(bankAClockOutputs),
    .bankBClockOutputs(bankBClockOutputs),
    .loopReturnOut(loopReturnOut), .phaseLocked(phaseLocked));

  pcf_ref_partner i_pcf_ref_partner (
    .mclk(mclk), .period(period), .highTime(highTime),
    .loopReturnOut(loopReturnOut), .refClkIn(refClkIn),
    .openLoop(openLoop), .loopReturnIn(loopReturnIn));

  always #4 mclk = ~mclk;

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a hang must not hide: the whole run needs well under this
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input int exp, input int got);
    numChecks++;
    if (exp != got)
    begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    numChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wait_lock(input logic val, input int limit);
    int n;
    for (n = 0; n < limit && phaseLocked !== val; n++)
      @(negedge mclk);
  endtask

  // counts over n cycles; a whole number of periods makes counts phase-free
  task automatic watch(input int n, input bit toggleA);
    logic prevLoop;
    logic prevA;
    logic [`PCF_BANK_A_N-1:0] expA;
    hiLoop = 0; riseLoop = 0; badA = 0; badB = 0;
    runts = 0; pulsesA = 0; runA = -1;
    prevLoop = loopReturnOut;
    prevA = bankAClockOutputs[0];
    repeat (n)
    begin
      @(negedge mclk);
      if (toggleA && cycles % 3 == 0)
        bankAEnable = ~bankAEnable;
      hiLoop += (loopReturnOut === 1'b1);
      riseLoop += (loopReturnOut === 1'b1 && prevLoop === 1'b0);
      expA = toggleA ? {`PCF_BANK_A_N{bankAClockOutputs[0] & loopReturnOut}}
                     : {`PCF_BANK_A_N{loopReturnOut & bankAEnable}};
      badA += (bankAClockOutputs !== expA);
      badB += (bankBClockOutputs !==
               {`PCF_BANK_B_N{loopReturnOut & bankBEnable}});
      if (bankAClockOutputs[0] === 1'b1 && prevA === 1'b0)
      begin
        runA = 0;
        pulsesA++;
      end
      if (bankAClockOutputs[0] === 1'b1 && runA >= 0)
        runA++;
      if (bankAClockOutputs[0] === 1'b0 && prevA === 1'b1 && runA >= 0)
        runts += (runA != int'(period) / 2);
      prevLoop = loopReturnOut;
      prevA = bankAClockOutputs[0];
    end
  endtask

  task automatic t_lock;
    wait_lock(1'b1, 200);
    check_bit("locked", 1'b1, phaseLocked);
    watch(32, 1'b0);
    check("loop highs", 16, hiLoop);
    check("loop rises", 4, riseLoop);
    $display("test lock done");
  endtask

  task automatic t_gates;
    int i;
    for (i = 0; i < 4; i++)
    begin
      bankAEnable = i[0];
      bankBEnable = i[1];
      repeat (16) @(negedge mclk);
      watch(32, 1'b0);
      check("bank a", 0, badA);
      check("bank b", 0, badB);
      check("loop rises gated", 4, riseLoop);
    end
    $display("test gates done");
  endtask

  task automatic t_runt;
    bankBEnable = 1'b1;
    watch(64, 1'b1);
    check("short pulses", 0, runts);
    check("bank a pairing", 0, badA);
    check_bit("pulses seen", 1'b1, pulsesA > 0);
    $display("test runt done");
  endtask

  task automatic t_retune;
    bankAEnable = 1'b1;
    period = 8'h07;
    wait_lock(1'b0, 24);
    check_bit("lock lost", 1'b0, phaseLocked);
    wait_lock(1'b1, 200);
    check_bit("relocked", 1'b1, phaseLocked);
    watch(28, 1'b0);
    check("odd highs", 12, hiLoop);
    check("odd rises", 4, riseLoop);
    $display("test retune done");
  endtask

  // a broken loop wire must drop lock; closing it again relocks
  task automatic t_open_loop;
    openLoop = 1'b1;
    wait_lock(1'b0, 16);
    check_bit("open loop unlock", 1'b0, phaseLocked);
    openLoop = 1'b0;
    wait_lock(1'b1, 200);
    check_bit("loop relocked", 1'b1, phaseLocked);
    $display("test open loop done");
  endtask

  // bypass keeps the reference duty, so highs reveal which path is live
  task automatic t_bypass;
    analogSupply = 1'b0;
    repeat (16) @(negedge mclk);
    watch(28, 1'b0);
    check("bypass highs", 8, hiLoop);
    check("bypass bank a", 0, badA);
    check_bit("bypass lock", 1'b0, phaseLocked);
    $display("test bypass done");
  endtask

  initial
  begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    t_lock();
    t_gates();
    t_runt();
    t_retune();
    t_open_loop();
    t_bypass();
    tally_and_finish();
  end
endmodule
